// File: verilog/qcs_pkg.sv
// qcs_pkg: constants shared by the qos classifier/scheduler block
// assumes a 32-bit classic wishbone register bus and one core clock
package qcs_pkg;
  localparam int QCS_NQ = 4;
  localparam int QCS_QW = 2;
  localparam int QCS_COSW = 3;
  localparam int QCS_DSCPW = 6;
  localparam int QCS_NDSCP = 64;
  localparam int QCS_NCOS = 8;
  localparam int QCS_WW = 4;
  // register byte offsets
  localparam logic [7:0] QCS_OFS_CTRL = 8'h00;
  localparam logic [7:0] QCS_OFS_PORT = 8'h04;
  localparam logic [7:0] QCS_OFS_COSMAP = 8'h08;
  localparam logic [7:0] QCS_OFS_STAT = 8'h0c;
  localparam logic [7:0] QCS_OFS_DSCP0 = 8'h10;
  localparam logic [7:0] QCS_OFS_DSCP_LAST = 8'h1c;
  localparam logic [7:0] QCS_OFS_CNT0 = 8'h20;
  localparam logic [7:0] QCS_OFS_CNT_LAST = 8'h2c;
  // fields
  localparam int QCS_CTRL_SP_BIT = 0;
  localparam int QCS_PORT_COS_LSB = 0;
  localparam int QCS_PORT_TRUST_LSB = 4;
  // reset values: cos 1,2->0  0,3->1  4,5->2  6,7->3
  localparam logic [15:0] QCS_COSMAP_RST = 16'hfa41;
  localparam logic [31:0] QCS_DSCP_WORD_RST = 32'h0000_0000;
  localparam logic [3:0] QCS_W3 = 4'h8;
  localparam logic [3:0] QCS_W2 = 4'h4;
  localparam logic [3:0] QCS_W1 = 4'h2;
  localparam logic [3:0] QCS_W0 = 4'h1;
  typedef enum logic [1:0] {
    QCS_TRUST_COS = 2'h0,
    QCS_TRUST_DSCP = 2'h1,
    QCS_TRUST_COS_FIRST = 2'h3,
    QCS_TRUST_DSCP_FIRST = 2'h2
  } qcs_trust_t;
  typedef enum logic [1:0] {
    QCS_S_IDLE = 2'h0,
    QCS_S_SEND = 2'h1
  } qcs_state_t;
endpackage

// File: verilog/qcs_sched.sv
// qcs_sched: egress scheduler over four queues, strict or 8:4:2:1 weighted
// assumes egress raises done_i for one cycle when the granted packet has left
`timescale 1ns/10ps
module qcs_sched
  import qcs_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic strict_i,
  input wire logic [QCS_NQ-1:0] q_nonempty_i,
  input wire logic done_i,
  output logic grant_valid_o,
  output logic [QCS_QW-1:0] grant_q_o,
  output logic busy_o
);
  qcs_state_t state_reg, state_next;
  logic [QCS_QW-1:0] q_reg, q_next;
  logic [QCS_QW-1:0] cur_reg, cur_next;
  logic [QCS_WW-1:0] cnt_reg, cnt_next;
  logic [QCS_WW-1:0] weight [QCS_NQ];

  assign weight[3] = QCS_W3;
  assign weight[2] = QCS_W2;
  assign weight[1] = QCS_W1;
  assign weight[0] = QCS_W0;

  always_comb begin
    logic found;
    logic [QCS_QW-1:0] c;
    logic [QCS_WW-1:0] n;
    found = 1'b0;
    c = cur_reg;
    n = cnt_reg;
    state_next = state_reg;
    q_next = q_reg;
    cur_next = cur_reg;
    cnt_next = cnt_reg;
    case (state_reg)
      QCS_S_IDLE: begin
        // the scheme is only looked at here, so a change waits for the packet to end
        if (strict_i) begin
          for (int i = 0; i < QCS_NQ; i++) begin
            if (q_nonempty_i[i]) begin
              q_next = QCS_QW'(i);
              found = 1'b1;
            end
          end
        end else begin
          // weighted walk from queue 3 down, then wrap to a new round
          for (int k = 0; k < QCS_NQ + 1; k++) begin
            if (!found) begin
              if (q_nonempty_i[c] && n < weight[c]) begin
                found = 1'b1;
                q_next = c;
                cur_next = c;
                cnt_next = n + 4'h1;
              end else begin
                c = (c == '0) ? QCS_QW'(QCS_NQ - 1) : c - 2'h1;
                n = '0;
              end
            end
          end
        end
        if (found) begin
          state_next = QCS_S_SEND;
        end
      end
      QCS_S_SEND: begin
        if (done_i) begin
          state_next = QCS_S_IDLE;
        end
      end
      default: state_next = QCS_S_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= QCS_S_IDLE;
      q_reg <= '0;
      cur_reg <= QCS_QW'(QCS_NQ - 1);
      cnt_reg <= '0;
    end else begin
      state_reg <= state_next;
      q_reg <= q_next;
      cur_reg <= cur_next;
      cnt_reg <= cnt_next;
    end
  end

  assign grant_valid_o = (state_reg == QCS_S_SEND);
  assign grant_q_o = q_reg;
  assign busy_o = grant_valid_o;
endmodule

// File: verilog/qcs_top.sv
// qcs_top: per-port frame classifier onto four egress queues plus scheduler
// assumes ingress offers one frame descriptor per cycle via cls_valid_i,
// egress takes grants and pulses done_i; registers over classic wishbone
//
// Contract
// - four egress queues numbered 0 lowest to 3 highest
// - weighted mode serves 8,4,2,1 packets per round from queue 3 down to 0
// - strict mode always serves the highest non-empty queue
// - a tagged frame's 3-bit priority is taken as unsigned 0 to 7
// - untagged frames take the port default priority, tagged frames their own
// - programmable priority to queue table, reset 1,2->0 0,3->1 4,5->2 6,7->3
// - priority-only trust, the reset default, uses the priority table only
// - dscp-only trust uses the dscp table only
// - priority-first uses priority table for tagged or non-ipv4 frames, else dscp table
// - dscp-first uses dscp table for ipv4 frames, else priority table
// - programmable dscp table, one queue entry per dscp value from 0
`timescale 1ns/10ps
module qcs_top
  import qcs_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  output logic err_o,
  input wire logic cls_valid_i,
  input wire logic cls_tagged_i,
  input wire logic [QCS_COSW-1:0] cls_pcp_i,
  input wire logic cls_ipv4_i,
  input wire logic [7:0] cls_tos_i,
  output logic cls_valid_o,
  output logic [QCS_QW-1:0] cls_queue_o,
  output logic [QCS_COSW-1:0] cls_pcp_o,
  input wire logic [QCS_NQ-1:0] q_nonempty_i,
  input wire logic done_i,
  output logic grant_valid_o,
  output logic [QCS_QW-1:0] grant_q_o
);
  logic strict_reg, strict_next;
  logic [QCS_COSW-1:0] dflt_cos_reg, dflt_cos_next;
  logic [1:0] trust_reg, trust_next;
  logic [2*QCS_NCOS-1:0] cosmap_reg, cosmap_next;
  logic [31:0] dscp_reg [4];
  logic [31:0] dscp_next [4];
  logic ack_reg, ack_next;
  logic err_reg, err_next;
  logic [31:0] rdat_reg, rdat_next;
  logic [31:0] cnt_reg [QCS_NQ];
  logic [31:0] cnt_next [QCS_NQ];
  logic ovalid_reg, ovalid_next;
  logic [QCS_QW-1:0] oq_reg, oq_next;
  logic [QCS_COSW-1:0] opcp_reg, opcp_next;
  logic sched_busy;

  function automatic logic [31:0] qcs_merge(input logic [31:0] old, input logic [31:0] d,
                                            input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        r[8*b +: 8] = d[8*b +: 8];
      end
    end
    return r;
  endfunction

  // register bus: one wait-free ack, or err for an unmapped address, the cycle after the request is seen
  always_comb begin
    logic req;
    logic [31:0] w;
    req = cyc_i && stb_i && !ack_reg && !err_reg;
    w = '0;
    strict_next = strict_reg;
    dflt_cos_next = dflt_cos_reg;
    trust_next = trust_reg;
    cosmap_next = cosmap_reg;
    for (int j = 0; j < 4; j++) begin
      dscp_next[j] = dscp_reg[j];
    end
    ack_next = 1'b0;
    err_next = 1'b0;
    rdat_next = rdat_reg;
    if (req) begin
      ack_next = 1'b1;
      rdat_next = '0;
      case (adr_i)
        QCS_OFS_CTRL: begin
          rdat_next[QCS_CTRL_SP_BIT] = strict_reg;
          if (we_i) begin
            w = qcs_merge({31'h0, strict_reg}, dat_i, sel_i);
            strict_next = w[QCS_CTRL_SP_BIT];
          end
        end
        QCS_OFS_PORT: begin
          rdat_next[QCS_PORT_COS_LSB +: QCS_COSW] = dflt_cos_reg;
          rdat_next[QCS_PORT_TRUST_LSB +: 2] = trust_reg;
          if (we_i) begin
            w = qcs_merge(rdat_next, dat_i, sel_i);
            dflt_cos_next = w[QCS_PORT_COS_LSB +: QCS_COSW];
            trust_next = w[QCS_PORT_TRUST_LSB +: 2];
          end
        end
        QCS_OFS_COSMAP: begin
          rdat_next[2*QCS_NCOS-1:0] = cosmap_reg;
          if (we_i) begin
            w = qcs_merge(rdat_next, dat_i, sel_i);
            cosmap_next = w[2*QCS_NCOS-1:0];
          end
        end
        QCS_OFS_STAT: begin
          rdat_next[0] = sched_busy;
          rdat_next[1] = strict_reg;
          rdat_next[QCS_NQ+1:2] = q_nonempty_i;
        end
        default: begin
          if (adr_i >= QCS_OFS_DSCP0 && adr_i <= QCS_OFS_DSCP_LAST && adr_i[1:0] == 2'h0) begin
            rdat_next = dscp_reg[adr_i[3:2]];
            if (we_i) begin
              dscp_next[adr_i[3:2]] = qcs_merge(dscp_reg[adr_i[3:2]], dat_i, sel_i);
            end
          end else if (adr_i >= QCS_OFS_CNT0 && adr_i <= QCS_OFS_CNT_LAST &&
                       adr_i[1:0] == 2'h0) begin
            rdat_next = cnt_reg[adr_i[3:2]];
          end else begin
            ack_next = 1'b0;
            err_next = 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      strict_reg <= 1'b0;
      dflt_cos_reg <= '0;
      trust_reg <= QCS_TRUST_COS;
      cosmap_reg <= QCS_COSMAP_RST;
      for (int j = 0; j < 4; j++) begin
        dscp_reg[j] <= QCS_DSCP_WORD_RST;
      end
      ack_reg <= 1'b0;
      err_reg <= 1'b0;
      rdat_reg <= '0;
    end else begin
      strict_reg <= strict_next;
      dflt_cos_reg <= dflt_cos_next;
      trust_reg <= trust_next;
      cosmap_reg <= cosmap_next;
      for (int j = 0; j < 4; j++) begin
        dscp_reg[j] <= dscp_next[j];
      end
      ack_reg <= ack_next;
      err_reg <= err_next;
      rdat_reg <= rdat_next;
    end
  end

  assign ack_o = ack_reg;
  assign err_o = err_reg;
  assign dat_o = rdat_reg;

  // classifier: one registered result per offered frame
  always_comb begin
    logic [QCS_COSW-1:0] pcp;
    logic [QCS_DSCPW-1:0] dscp;
    logic [QCS_QW-1:0] qc;
    logic [QCS_QW-1:0] qd;
    logic [31:0] dw;
    pcp = cls_tagged_i ? cls_pcp_i : dflt_cos_reg;
    dscp = cls_tos_i[7:2];
    qc = cosmap_reg[2*pcp +: 2];
    dw = dscp_reg[dscp[5:4]];
    qd = dw[2*dscp[3:0] +: 2];
    ovalid_next = cls_valid_i;
    opcp_next = cls_valid_i ? pcp : opcp_reg;
    oq_next = oq_reg;
    if (cls_valid_i) begin
      case (trust_reg)
        QCS_TRUST_COS: oq_next = qc;
        QCS_TRUST_DSCP: oq_next = qd;
        QCS_TRUST_COS_FIRST: oq_next = cls_tagged_i ? qc : (cls_ipv4_i ? qd : qc);
        QCS_TRUST_DSCP_FIRST: oq_next = cls_ipv4_i ? qd : qc;
        default: oq_next = qc;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ovalid_reg <= 1'b0;
      oq_reg <= '0;
      opcp_reg <= '0;
    end else begin
      ovalid_reg <= ovalid_next;
      oq_reg <= oq_next;
      opcp_reg <= opcp_next;
    end
  end

  // sent-packet statistics, one counter per egress queue, counted on done
  always_comb begin
    for (int i = 0; i < QCS_NQ; i++) begin
      cnt_next[i] = cnt_reg[i];
      if (grant_valid_o && done_i && grant_q_o == QCS_QW'(i)) begin
        cnt_next[i] = cnt_reg[i] + 32'h1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < QCS_NQ; i++) begin
        cnt_reg[i] <= '0;
      end
    end else begin
      for (int i = 0; i < QCS_NQ; i++) begin
        cnt_reg[i] <= cnt_next[i];
      end
    end
  end

  assign cls_valid_o = ovalid_reg;
  assign cls_queue_o = oq_reg;
  assign cls_pcp_o = opcp_reg;

  qcs_sched u_sched (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .strict_i(strict_reg),
    .q_nonempty_i(q_nonempty_i),
    .done_i(done_i),
    .grant_valid_o(grant_valid_o),
    .grant_q_o(grant_q_o),
    .busy_o(sched_busy)
  );
endmodule

// File: tb/qcs_top_properties.sv
// qcs_top_properties: concurrent checks on the qcs_top ports
// assumes one core clock and a synchronous active-high reset
`timescale 1ns/10ps
module qcs_top_properties
  import qcs_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic ack_o,
  input wire logic err_o,
  input wire logic cls_valid_i,
  input wire logic cls_tagged_i,
  input wire logic [QCS_COSW-1:0] cls_pcp_i,
  input wire logic cls_valid_o,
  input wire logic [QCS_COSW-1:0] cls_pcp_o,
  input wire logic [QCS_NQ-1:0] q_nonempty_i,
  input wire logic done_i,
  input wire logic grant_valid_o,
  input wire logic [QCS_QW-1:0] grant_q_o
);
  logic [QCS_NQ-1:0] qn_reg;
  always_ff @(posedge clk_i) begin
    qn_reg <= q_nonempty_i;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_bus_answer: assert property (cyc_i && stb_i && !ack_o && !err_o |=> ack_o || err_o)
    else $error("bus request not answered");
  a_cls_answer: assert property (cls_valid_i |=> cls_valid_o)
    else $error("frame not classified");
  a_cls_quiet: assert property (!cls_valid_i |=> !cls_valid_o)
    else $error("result without frame");
  a_tag_prio: assert property (cls_valid_i && cls_tagged_i |=> cls_pcp_o == $past(cls_pcp_i))
    else $error("tag priority lost");
  a_grant_start: assert property (!grant_valid_o && |q_nonempty_i |=> grant_valid_o)
    else $error("waiting queue not served");
  a_no_idle_grant: assert property (!grant_valid_o && !(|q_nonempty_i) |=> !grant_valid_o)
    else $error("grant with all queues empty");
  a_grant_hold: assert property (grant_valid_o && !done_i |=> grant_valid_o && $stable(grant_q_o))
    else $error("grant changed mid packet");
  a_grant_end: assert property (grant_valid_o && done_i |=> !grant_valid_o)
    else $error("grant kept after done");
  a_grant_filled: assert property ($rose(grant_valid_o) |-> qn_reg[grant_q_o])
    else $error("grant to empty queue");
  c_err: cover property (err_o);
  c_low_grant: cover property ($rose(grant_valid_o) && grant_q_o == 2'h0);
  c_untagged: cover property (cls_valid_i && !cls_tagged_i);
endmodule

// File: tb/qcs_egress_model.sv
// qcs_egress_model: egress side, ends each granted packet, alternately fast and slow
// assumes the scheduler holds its grant until the done pulse
`timescale 1ns/10ps
module qcs_egress_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic grant_valid_i,
  output logic done_o
);
  logic [1:0] cnt_reg;
  logic slow_reg;
  always_ff @(posedge clk_i) begin
    if (rst_i || done_o) begin
      done_o <= 1'b0;
      cnt_reg <= 2'h0;
      slow_reg <= rst_i ? 1'b0 : !slow_reg;
    end else if (grant_valid_i) begin
      if (cnt_reg == (slow_reg ? 2'h3 : 2'h0)) done_o <= 1'b1;
      else cnt_reg <= cnt_reg + 2'h1;
    end
  end
endmodule

// File: tb/qcs_top_tb_top.sv
// qcs_top_tb_top: register, classifier and scheduler sequences on qcs_top
// assumes the egress model answers grants; the bench holds queue levels
`timescale 1ns/10ps
module qcs_top_tb_top;
  import qcs_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'hf;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o, rd;
  logic ack_o, err_o, cls_valid_o, done_i, grant_valid_o;
  logic cls_valid_i = 1'b0;
  logic cls_tagged_i = 1'b0;
  logic cls_ipv4_i = 1'b0;
  logic [2:0] cls_pcp_i = 3'h0;
  logic [7:0] cls_tos_i = 8'h00;
  logic [1:0] cls_queue_o, grant_q_o, gq;
  logic [2:0] cls_pcp_o;
  logic [3:0] q_nonempty_i = 4'h0;
  logic [1:0] cq [8] = '{2'h1, 2'h0, 2'h0, 2'h1, 2'h2, 2'h2, 2'h3, 2'h3};
  int err_count = 0;
  int tests_run = 0;
  always #10 clk_i = ~clk_i;
  qcs_top dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
    .err_o, .cls_valid_i, .cls_tagged_i, .cls_pcp_i, .cls_ipv4_i, .cls_tos_i, .cls_valid_o,
    .cls_queue_o, .cls_pcp_o, .q_nonempty_i, .done_i, .grant_valid_o, .grant_q_o);
  qcs_egress_model eg (.clk_i, .rst_i, .grant_valid_i(grant_valid_o), .done_o(done_i));
  task automatic close_out();
    if (err_count == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic e);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (!(ack_o || err_o) && n < 50);
    if (n >= 50) begin
      err_count++;
      close_out();
    end
    chk({31'h0, err_o}, {31'h0, e});
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask
  task automatic cls(input logic t, input logic [2:0] p, input logic v, input logic [7:0] s,
    input logic [1:0] q, input logic [2:0] pe);
    @(posedge clk_i);
    cls_valid_i <= 1'b1;
    cls_tagged_i <= t;
    cls_pcp_i <= p;
    cls_ipv4_i <= v;
    cls_tos_i <= s;
    @(posedge clk_i);
    cls_valid_i <= 1'b0;
    @(posedge clk_i);
    chk({26'h0, cls_valid_o, cls_queue_o, cls_pcp_o}, {26'h0, 1'b1, q, pe});
  endtask
  task automatic grant(output logic [1:0] q);
    int n;
    n = 0;
    while (grant_valid_o && n < 50) begin
      @(posedge clk_i);
      n++;
    end
    while (!grant_valid_o && n < 50) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 50) begin
      err_count++;
      close_out();
    end
    q = grant_q_o;
  endtask
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, QCS_OFS_COSMAP, 32'h0, 1'b0);
    chk(rd, 32'h0000_fa41);
    wb(1'b0, 8'h40, 32'h0, 1'b1);
    for (int c = 0; c < 8; c++) cls(1'b1, c[2:0], 1'b1, 8'hfc, cq[c], c[2:0]);
    wb(1'b1, QCS_OFS_COSMAP, 32'h0000_fa43, 1'b0);
    cls(1'b1, 3'h0, 1'b0, 8'h00, 2'h3, 3'h0);
    wb(1'b1, QCS_OFS_PORT, 32'h0000_0005, 1'b0);
    cls(1'b0, 3'h7, 1'b0, 8'h00, 2'h2, 3'h5);
    wb(1'b1, QCS_OFS_DSCP0, 32'h0000_0008, 1'b0);
    wb(1'b1, QCS_OFS_DSCP_LAST, 32'hffff_ffff, 1'b0);
    wb(1'b1, QCS_OFS_PORT, 32'h0000_0015, 1'b0);
    cls(1'b1, 3'h7, 1'b1, 8'h07, 2'h2, 3'h7);
    cls(1'b0, 3'h0, 1'b1, 8'hfc, 2'h3, 3'h5);
    wb(1'b1, QCS_OFS_PORT, 32'h0000_0025, 1'b0);
    cls(1'b1, 3'h7, 1'b1, 8'h04, 2'h2, 3'h7);
    cls(1'b1, 3'h1, 1'b0, 8'hfc, 2'h0, 3'h1);
    wb(1'b1, QCS_OFS_PORT, 32'h0000_0035, 1'b0);
    cls(1'b1, 3'h1, 1'b1, 8'hfc, 2'h0, 3'h1);
    cls(1'b0, 3'h0, 1'b1, 8'hfc, 2'h3, 3'h5);
    q_nonempty_i <= 4'hf;
    for (int i = 0; i < 15; i++) begin
      grant(gq);
      chk({30'h0, gq}, {30'h0, i < 8 ? 2'h3 : i < 12 ? 2'h2 : i < 14 ? 2'h1 : 2'h0});
    end
    wb(1'b1, QCS_OFS_CTRL, 32'h0000_0001, 1'b0);
    wb(1'b0, QCS_OFS_STAT, 32'h0, 1'b0);
    chk(rd & 32'h3e, 32'h3e);
    grant(gq);
    grant(gq);
    for (int i = 0; i < 4; i++) begin
      grant(gq);
      chk({30'h0, gq}, 32'h3);
    end
    q_nonempty_i <= 4'h3;
    grant(gq);
    grant(gq);
    grant(gq);
    chk({30'h0, gq}, 32'h1);
    q_nonempty_i <= 4'h0;
    repeat (10) @(posedge clk_i);
    wb(1'b0, QCS_OFS_CNT0, 32'h0, 1'b0);
    chk(rd, 32'h1);
    wb(1'b0, QCS_OFS_CNT0 + 8'h08, 32'h0, 1'b0);
    chk(rd, 32'h4);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, QCS_OFS_COSMAP, 32'h0, 1'b0);
    chk(rd, 32'h0000_fa41);
    wb(1'b0, QCS_OFS_PORT, 32'h0, 1'b0);
    chk(rd, 32'h0);
    wb(1'b0, QCS_OFS_CNT0 + 8'h08, 32'h0, 1'b0);
    chk(rd, 32'h0);
    close_out();
  end
endmodule
bind qcs_top qcs_top_properties chk_u (.clk_i, .rst_i, .cyc_i, .stb_i, .ack_o, .err_o,
  .cls_valid_i, .cls_tagged_i, .cls_pcp_i, .cls_valid_o, .cls_pcp_o, .q_nonempty_i, .done_i,
  .grant_valid_o, .grant_q_o);
